// [design/mmd_pkg.sv]
package mmd_pkg;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [31:0] ALIAS_BASE     = 32'h0000_0000;
    localparam logic [31:0] ALIAS_SIZE     = 32'h0001_0000;
    localparam logic [31:0] SRAM_BASE      = 32'h0001_0000;
    localparam logic [31:0] SRAM_BYTES     = 32'h0000_2000;
    localparam logic [31:0] NVM_BLK1_BASE  = 32'h0008_0000;
    localparam logic [31:0] NVM_BLK0_BASE  = 32'h0009_0000;
    localparam logic [31:0] NVM_BLK0_END   = 32'h0009_f700;
    localparam logic [31:0] NVM_BOOT_BASE  = 32'h0009_f800;
    localparam logic [31:0] NVM_END        = 32'h000a_0000;
    localparam logic [31:0] MMR_BASE       = 32'hffff_0000;
    localparam logic [31:0] IRQ_BASE       = 32'hffff_0000;
    localparam logic [31:0] SYS_BASE       = 32'hffff_0200;
    localparam logic [31:0] SYS_END        = 32'hffff_0300;
    localparam logic [31:0] GPIO_BASE      = 32'hffff_0d00;
    localparam logic [31:0] FLCTL_END      = 32'hffff_0f00;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int          SRAM_WORDS     = 2048;
    localparam int          SRAM_AW        = 11;
    localparam int          NVM_AW         = 16;
    localparam int          NVM_PAGE_SHIFT = 9;
    localparam int          NVM_PAGE_W     = 8;
    localparam logic [31:0] NVM_USER_BYTES = 32'h0001_f800;
    localparam logic [31:0] NVM_BOOT_BYTES = 32'h0000_0800;

    // ------------------------------------------------------------
    // System control registers (offsets within PERIPHERAL_REGISTER_SPACE page)
    // ------------------------------------------------------------
    localparam logic [15:0] OFS_ADDR_ZERO_SELECT  = 16'h0220;
    localparam logic [15:0] OFS_RESET_CAUSE_FLAGS = 16'h0230;
    localparam logic [15:0] OFS_RESET_CAUSE_CLEAR = 16'h0234;
    localparam logic [15:0] OFS_RESET_KEY_FIRST   = 16'h0248;
    localparam logic [15:0] OFS_RESET_SETUP       = 16'h024c;
    localparam logic [15:0] OFS_RESET_KEY_SECOND  = 16'h0250;
    localparam logic        RST_ADDR_ZERO_SELECT  = 1'b1;
    localparam logic [7:0]  RST_RESET_CAUSE       = 8'h00;
    localparam logic [7:0]  RST_RESET_SETUP       = 8'h00;
    // Key values are arbitrary
    localparam logic [7:0]  KEY_FIRST_VALUE       = 8'h5a;
    localparam logic [7:0]  KEY_SECOND_VALUE      = 8'ha5;

    // ------------------------------------------------------------
    // Access types
    // ------------------------------------------------------------
    localparam logic [1:0]  SIZE_BYTE = 2'h0;
    localparam logic [1:0]  SIZE_HALF = 2'h1;
    localparam logic [1:0]  SIZE_WORD = 2'h2;

    typedef enum {ST_IDLE, ST_WAIT, ST_RESP} mmd_state_t;
    typedef enum {SRC_ZERO, SRC_REG, SRC_SRAM, SRC_NVM, SRC_PERI} mmd_src_t;

endpackage

// [design/mmd_sram.sv]
module mmd_sram
    import mmd_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                en,
    input  wire logic                we,
    input  wire logic [3:0]          byteEn,
    input  wire logic [SRAM_AW-1:0]  addr,
    input  wire logic [31:0]         wdata,
    output logic      [31:0]         rdata
);

    // ------------------------------------------------------------
    // Word array, byte lanes little endian
    // ------------------------------------------------------------
    logic [31:0] mem [SRAM_WORDS];
    logic [31:0] rdata_q;

    always_ff @(posedge ref_clk) begin
        if (en && we) begin
            for (int i = 0; i < 4; i++) begin
                if (byteEn[i]) begin
                    mem[addr][8*i +: 8] <= wdata[8*i +: 8]; // RULE_03
                end
            end
        end
        if (en) begin
            rdata_q <= mem[addr]; // RULE_04
        end
    end

    assign rdata = rdata_q;

endmodule

// [design/mmd_decoder.sv]
// Summary of operation
// RULE_01 - After reset, address zero aliases nonvolatile memory.
// RULE_02 - Clearing bit 0 of address_zero_select puts SRAM at address zero.
// RULE_03 - Little-endian: least significant byte at lowest address.
// RULE_04 - SRAM is 2048 words of 32 bits, one access per word.
// RULE_05 - Nonvolatile is 16 bits wide; word fetch takes two half accesses.
// RULE_06 - Block zero from 0x90000; top 1k half-words are boot page.
// RULE_07 - Block one from 0x80000 to 0x90000, all user space.
// RULE_08 - 126 kB user nonvolatile space, 2 kB boot page.
// RULE_09 - Nonvolatile pages are 512 bytes.
// RULE_10 - Register space fills the top two pages of the address range.
// RULE_11 - Fast bus accesses take one cycle, peripheral bus two.
// RULE_12 - Nonvolatile and GPIO on fast bus, other peripherals on slow bus.
// RULE_13 - Interrupt controller decoded from 0xFFFF0000, one-cycle access.
// RULE_14 - System control decoded from 0xFFFF0200, one-cycle access.
// RULE_15 - Software should avoid unoccupied register locations.
// RULE_16 - Remap bit resets to one.
module mmd_decoder
    import mmd_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire logic               reqValid,
    output logic                    reqReady,
    input  wire logic [31:0]        reqAddr,
    input  wire logic               reqWrite,
    input  wire logic [1:0]         reqSize,
    input  wire logic [31:0]        reqWdata,
    output logic                    respValid,
    output logic [31:0]             respRdata,
    output logic                    respUnmapped,
    output logic                    nvmRead,
    output logic [NVM_AW-1:0]       nvmAddr,
    input  wire logic [15:0]        nvmRdata,
    output logic                    nvmBootPage,
    output logic [NVM_PAGE_W-1:0]   nvmPage,
    output logic                    periphSel,
    output logic                    periphFast,
    output logic                    periphWrite,
    output logic [15:0]             periphAddr,
    output logic [31:0]             periphWdata,
    input  wire logic [31:0]        periphRdata,
    input  wire logic [7:0]         resetCauseSet,
    output logic                    addrZeroSelect,
    output logic [7:0]              resetSetup
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic        inAlias, toNvm, toSram, toSys, toMmr, mmrFast, mapped;
    logic [31:0] nvmOfs, sramOfs, physAddr;
    logic        accept, isWord, nvmTwo;
    logic [15:0] mmrOfs;

    assign accept  = reqValid && reqReady;
    assign inAlias = (reqAddr - ALIAS_BASE) < ALIAS_SIZE;
    always_comb begin
        physAddr = reqAddr;
        if (inAlias) begin
            physAddr = addrZeroSelect ? (reqAddr + NVM_BLK1_BASE) // RULE_01
                                      : (reqAddr + SRAM_BASE);     // RULE_02
        end
    end
    assign toNvm   = (physAddr >= NVM_BLK1_BASE) && (physAddr < NVM_END); // RULE_06 RULE_07
    assign toSram  = (physAddr >= SRAM_BASE) && (physAddr < SRAM_BASE + SRAM_BYTES);
    assign toMmr   = reqAddr >= MMR_BASE; // RULE_10
    assign mmrOfs  = reqAddr[15:0];
    assign toSys   = toMmr && (reqAddr >= SYS_BASE) && (reqAddr < SYS_END); // RULE_14
    assign mmrFast = toMmr && ((reqAddr < SYS_END)                           // RULE_13
                   || ((reqAddr >= GPIO_BASE) && (reqAddr < FLCTL_END)));  // RULE_12
    assign mapped  = toNvm || toSram || toMmr;
    assign nvmOfs  = physAddr - NVM_BLK1_BASE;
    assign sramOfs = physAddr - SRAM_BASE;
    assign isWord  = reqSize == SIZE_WORD;
    assign nvmTwo  = toNvm && isWord && !reqWrite; // RULE_05

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    mmd_state_t  state_q, state_d;
    mmd_src_t    src_q, src_d;
    logic [31:0] addr_q, addr_d;
    logic [15:0] nvmLow_q, nvmLow_d;
    logic        slow_q, slow_d;
    logic        unm_q, unm_d;
    logic        nvmHiHalf_q, nvmHiHalf_d;
    logic [31:0] wdata_q, wdata_d;
    logic        write_q, write_d, wasTwo_q, wasTwo_d;

    always_comb begin
        state_d     = state_q;
        src_d       = src_q;
        addr_d      = addr_q;
        nvmLow_d    = nvmLow_q;
        slow_d      = slow_q;
        unm_d       = unm_q;
        nvmHiHalf_d = nvmHiHalf_q;
        wdata_d     = wdata_q;
        write_d     = write_q;
        wasTwo_d    = state_q == ST_WAIT;
        case (state_q)
            ST_IDLE: begin
                if (reqValid) begin
                    addr_d      = physAddr;
                    unm_d       = !mapped;
                    slow_d      = toMmr && !mmrFast && !toSys;
                    nvmHiHalf_d = physAddr[1];
                    wdata_d     = reqWdata;
                    write_d     = reqWrite;
                    if (toSys) begin
                        src_d = SRC_REG;
                    end else if (toMmr) begin
                        src_d = SRC_PERI;
                    end else if (toSram) begin
                        src_d = SRC_SRAM;
                    end else if (toNvm) begin
                        src_d = SRC_NVM;
                    end else begin
                        src_d = SRC_ZERO;
                    end
                    if (nvmTwo || (toMmr && !mmrFast)) begin
                        state_d = ST_WAIT; // RULE_11
                    end else begin
                        state_d = ST_RESP; // RULE_11
                    end
                end
            end
            ST_WAIT: begin
                nvmLow_d = nvmRdata; // RULE_05
                state_d = ST_RESP;
            end
            ST_RESP: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q     <= ST_IDLE;
            src_q       <= SRC_ZERO;
            addr_q      <= 32'h0000_0000;
            nvmLow_q    <= 16'h0000;
            slow_q      <= 1'b0;
            unm_q       <= 1'b0;
            nvmHiHalf_q <= 1'b0;
            wdata_q     <= 32'h0000_0000;
            write_q     <= 1'b0;
            wasTwo_q    <= 1'b0;
        end else begin
            state_q     <= state_d;
            src_q       <= src_d;
            addr_q      <= addr_d;
            nvmLow_q    <= nvmLow_d;
            slow_q      <= slow_d;
            unm_q       <= unm_d;
            nvmHiHalf_q <= nvmHiHalf_d;
            wdata_q     <= wdata_d;
            write_q     <= write_d;
            wasTwo_q    <= wasTwo_d;
        end
    end

    assign reqReady     = state_q == ST_IDLE;
    assign respValid    = state_q == ST_RESP;
    assign respUnmapped = respValid && unm_q;

    // ------------------------------------------------------------
    // SRAM
    // ------------------------------------------------------------
    logic [3:0]  byteEn;
    logic [31:0] sramRdata;

    always_comb begin
        case (reqSize)
            SIZE_BYTE: byteEn = 4'h1 << reqAddr[1:0]; // RULE_03
            SIZE_HALF: byteEn = reqAddr[1] ? 4'hc : 4'h3;
            default:   byteEn = 4'hf;
        endcase
    end

    mmd_sram u_sram (
        .ref_clk (ref_clk),
        .en      (accept && toSram),
        .we      (reqWrite),
        .byteEn  (byteEn),
        .addr    (sramOfs[SRAM_AW+1:2]), // RULE_04
        .wdata   (reqWdata),
        .rdata   (sramRdata)
    );

    // ------------------------------------------------------------
    // Nonvolatile half-word port
    // ------------------------------------------------------------
    logic [31:0] nvmWaitOfs;
    assign nvmWaitOfs  = addr_q - NVM_BLK1_BASE;
    assign nvmRead     = (accept && toNvm && !reqWrite)
                       || (state_q == ST_WAIT && src_q == SRC_NVM);  // RULE_05
    assign nvmAddr     = (state_q == ST_WAIT) ? (nvmWaitOfs[NVM_AW:1] | 16'h0001)
                                              : nvmOfs[NVM_AW:1];
    assign nvmBootPage = nvmRead && (((state_q == ST_WAIT) ? addr_q : physAddr)
                       >= NVM_BOOT_BASE); // RULE_06 RULE_08
    assign nvmPage     = (state_q == ST_WAIT) ? nvmWaitOfs[NVM_PAGE_SHIFT +: NVM_PAGE_W]
                                              : nvmOfs[NVM_PAGE_SHIFT +: NVM_PAGE_W]; // RULE_09

    // ------------------------------------------------------------
    // Peripheral register port
    // ------------------------------------------------------------
    assign periphSel   = (accept && toMmr && !toSys)
                       || (state_q == ST_WAIT && src_q == SRC_PERI); // RULE_12
    assign periphFast  = reqReady ? mmrFast : !slow_q;
    assign periphWrite = reqReady ? reqWrite : write_q;
    assign periphAddr  = reqReady ? mmrOfs : addr_q[15:0];
    assign periphWdata = reqReady ? reqWdata : wdata_q;

    // ------------------------------------------------------------
    // System control registers
    // ------------------------------------------------------------
    logic       remap_q, remap_d, armed_q, armed_d;
    logic [7:0] cause_q, cause_d, setup_q, setup_d, pend_q, pend_d, regRd_q, regRd_d;
    logic       sysWr;

    assign sysWr = accept && toSys && reqWrite;
    always_comb begin
        remap_d = remap_q;
        armed_d = armed_q;
        setup_d = setup_q;
        pend_d  = pend_q;
        regRd_d = regRd_q;
        cause_d = cause_q;
        if (sysWr && mmrOfs == OFS_RESET_CAUSE_CLEAR) begin
            cause_d = cause_q & ~reqWdata[7:0];
        end
        cause_d = cause_d | resetCauseSet;
        if (sysWr) begin
            armed_d = 1'b0;
            case (mmrOfs)
                OFS_ADDR_ZERO_SELECT: remap_d = reqWdata[0]; // RULE_02
                OFS_RESET_KEY_FIRST:  armed_d = reqWdata[7:0] == KEY_FIRST_VALUE;
                OFS_RESET_SETUP: begin
                    armed_d = armed_q;
                    pend_d  = reqWdata[7:0];
                end
                OFS_RESET_KEY_SECOND: begin
                    if (armed_q && reqWdata[7:0] == KEY_SECOND_VALUE) begin
                        setup_d = pend_q;
                    end
                end
                default: armed_d = 1'b0;
            endcase
        end
        if (accept && toSys && !reqWrite) begin
            case (mmrOfs)
                OFS_ADDR_ZERO_SELECT:  regRd_d = {7'h00, remap_q};
                OFS_RESET_CAUSE_FLAGS: regRd_d = cause_q;
                OFS_RESET_SETUP:       regRd_d = setup_q;
                default:               regRd_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            remap_q <= RST_ADDR_ZERO_SELECT; // RULE_16 RULE_01
            armed_q <= 1'b0;
            cause_q <= RST_RESET_CAUSE;
            setup_q <= RST_RESET_SETUP;
            pend_q  <= RST_RESET_SETUP;
            regRd_q <= 8'h00;
        end else begin
            remap_q <= remap_d;
            armed_q <= armed_d;
            cause_q <= cause_d;
            setup_q <= setup_d;
            pend_q  <= pend_d;
            regRd_q <= regRd_d;
        end
    end

    assign addrZeroSelect = remap_q;
    assign resetSetup     = setup_q;

    // ------------------------------------------------------------
    // Answer data
    // ------------------------------------------------------------
    always_comb begin
        case (src_q)
            SRC_REG:  respRdata = {24'h000000, regRd_q};
            SRC_SRAM: respRdata = sramRdata;
            SRC_NVM:  respRdata = slow_q ? 32'h0000_0000 :
                        (wasTwo_q ? {nvmRdata, nvmLow_q}                    // RULE_03
                                      : (nvmHiHalf_q ? {nvmRdata, 16'h0000}
                                                     : {16'h0000, nvmRdata}));
            SRC_PERI: respRdata = periphRdata;
            default:  respRdata = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_ALIAS_NVM: assert property (accept && inAlias && addrZeroSelect |-> toNvm) // RULE_01
        else $error("Zero alias did not reach nonvolatile memory");
    AST_ALIAS_SRAM: assert property (accept && inAlias && !addrZeroSelect |-> !toNvm) // RULE_02
        else $error("Zero alias reached nonvolatile memory while remapped");
    AST_REMAP_WRITE: assert property (sysWr && mmrOfs == OFS_ADDR_ZERO_SELECT // RULE_02
        |=> addrZeroSelect == $past(reqWdata[0]))
        else $error("Remap bit did not follow write");
    AST_FAST_ONE: assert property (accept && (toSys || toSram || (toMmr && mmrFast)) // RULE_11
        |=> respValid)
        else $error("Fast access did not answer in one cycle");
    AST_SLOW_TWO: assert property (accept && toMmr && !mmrFast // RULE_11
        |=> !respValid ##1 respValid)
        else $error("Peripheral bus access did not take two cycles");
    AST_IRQ_FAST: assert property (accept && reqAddr[31:9] == IRQ_BASE[31:9] // RULE_13
        |-> periphSel && periphFast)
        else $error("Interrupt controller group not fast");
    AST_NVM_SPLIT: assert property (accept && nvmTwo // RULE_05
        |-> nvmRead ##1 (nvmRead && nvmAddr[0]) ##1 (respValid && !nvmRead))
        else $error("Word fetch not split into two half accesses");
    AST_BOOT_PAGE: assert property (nvmRead |-> nvmBootPage // RULE_06
        == ({nvmAddr, 1'b0} >= 17'(NVM_BOOT_BASE - NVM_BLK1_BASE)))
        else $error("Boot page flag wrong");
    AST_CAUSE_SET: assert property (|resetCauseSet |=> (cause_q & $past(resetCauseSet)) == $past(resetCauseSet))
        else $error("Reset cause lost against clear");

    COV_REMAP: cover property (sysWr && mmrOfs == OFS_ADDR_ZERO_SELECT && !reqWdata[0]);
    COV_NVM_WORD: cover property (accept && nvmTwo);
    COV_SLOW: cover property (accept && toMmr && !mmrFast);
    COV_SRAM: cover property (accept && toSram && !inAlias);

endmodule

// [tb/mmd_target_model.sv]
module mmd_target_model
    import mmd_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              nvmRead,
    input  wire logic [NVM_AW-1:0] nvmAddr,
    output logic      [15:0]       nvmRdata,
    input  wire logic              periphSel,
    input  wire logic [15:0]       periphAddr,
    output logic      [31:0]       periphRdata
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Half-word data made from the address, valid the cycle after a read
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (nvmRead) begin
            nvmRdata <= nvmAddr ^ 16'h3c00;
        end else begin
            nvmRdata <= ~nvmRdata;
        end
    end

    // ------------------------------------------------------------
    // Peripheral answer made from the address, valid the cycle after each select cycle
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (periphSel) begin
            periphRdata <= {16'ha5c3, periphAddr};
        end else begin
            periphRdata <= ~periphRdata;
        end
    end
endmodule

// [tb/tb_memory_map_decoder_remap.sv]
module tb_memory_map_decoder_remap
    import mmd_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {
        logic [31:0] a;
        logic        w;
        logic [1:0]  s;
        logic [31:0] d;
        logic [31:0] r;
        int          lat;
        logic        u;
    } mmd_row_t;

    logic ref_clk, rst, reqValid, reqReady, reqWrite, respValid, respUnmapped;
    logic nvmRead, nvmBootPage, periphSel, periphFast, periphWrite, addrZeroSelect;
    logic [31:0] reqAddr, reqWdata, respRdata, periphWdata, periphRdata;
    logic [1:0] reqSize;
    logic [NVM_AW-1:0] nvmAddr;
    logic [15:0] nvmRdata, periphAddr;
    logic [NVM_PAGE_W-1:0] nvmPage, pageSeen;
    logic [7:0] resetCauseSet, resetSetup;
    logic bootSeen, fastSeen, wrSeen;
    logic [31:0] wdSeen;
    int errTotal = 0;
    int cmpCount = 0;

    mmd_row_t rows [18] = '{
        '{32'hffff_0220, 1'b0, SIZE_WORD, 32'h0, 32'h0000_0001, 1, 1'b0},
        '{32'h0000_0000, 1'b0, SIZE_WORD, 32'h0, 32'h3c01_3c00, 2, 1'b0},
        '{32'h0008_0004, 1'b0, SIZE_WORD, 32'h0, 32'h3c03_3c02, 2, 1'b0},
        '{32'h0009_0000, 1'b0, SIZE_WORD, 32'h0, 32'hbc01_bc00, 2, 1'b0},
        '{32'h0001_0000, 1'b1, SIZE_WORD, 32'h1122_3344, 32'h0, 1, 1'b0},
        '{32'h0001_0002, 1'b1, SIZE_BYTE, 32'h00aa_0000, 32'h0, 1, 1'b0},
        '{32'h0001_0000, 1'b0, SIZE_WORD, 32'h0, 32'h11aa_3344, 1, 1'b0},
        '{32'h0001_1ffc, 1'b1, SIZE_WORD, 32'hcafe_0001, 32'h0, 1, 1'b0},
        '{32'h0001_1ffc, 1'b0, SIZE_WORD, 32'h0, 32'hcafe_0001, 1, 1'b0},
        '{32'hffff_0000, 1'b0, SIZE_WORD, 32'h0, 32'ha5c3_0000, 1, 1'b0},
        '{32'hffff_0300, 1'b0, SIZE_WORD, 32'h0, 32'ha5c3_0300, 2, 1'b0},
        '{32'hffff_0d00, 1'b0, SIZE_WORD, 32'h0, 32'ha5c3_0d00, 1, 1'b0},
        '{32'h0020_0000, 1'b0, SIZE_WORD, 32'h0, 32'h0, 1, 1'b1},
        '{32'h0008_0000, 1'b1, SIZE_WORD, 32'h0, 32'h0, 1, 1'b0},
        '{32'h0008_0000, 1'b0, SIZE_WORD, 32'h0, 32'h3c01_3c00, 2, 1'b0},
        '{32'hffff_0220, 1'b1, SIZE_WORD, 32'h0, 32'h0, 1, 1'b0},
        '{32'h0000_0000, 1'b0, SIZE_WORD, 32'h0, 32'h11aa_3344, 1, 1'b0},
        '{32'hffff_0220, 1'b1, SIZE_WORD, 32'h1, 32'h0, 1, 1'b0}
    };

    mmd_decoder i_dut (.ref_clk(ref_clk), .rst(rst), .reqValid(reqValid),
        .reqReady(reqReady), .reqAddr(reqAddr), .reqWrite(reqWrite), .reqSize(reqSize),
        .reqWdata(reqWdata), .respValid(respValid), .respRdata(respRdata),
        .respUnmapped(respUnmapped), .nvmRead(nvmRead), .nvmAddr(nvmAddr),
        .nvmRdata(nvmRdata), .nvmBootPage(nvmBootPage), .nvmPage(nvmPage),
        .periphSel(periphSel), .periphFast(periphFast), .periphWrite(periphWrite),
        .periphAddr(periphAddr), .periphWdata(periphWdata), .periphRdata(periphRdata),
        .resetCauseSet(resetCauseSet), .addrZeroSelect(addrZeroSelect),
        .resetSetup(resetSetup));

    mmd_target_model i_tgt (.ref_clk(ref_clk), .nvmRead(nvmRead), .nvmAddr(nvmAddr),
        .nvmRdata(nvmRdata), .periphSel(periphSel), .periphAddr(periphAddr),
        .periphRdata(periphRdata));

    // ------------------------------------------------------------
    // Clock, monitor and shared tasks
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    always @(negedge ref_clk) begin
        if (nvmRead === 1'b1) begin
            bootSeen = nvmBootPage;
            pageSeen = nvmPage;
        end
        if (periphSel === 1'b1) begin
            fastSeen = periphFast;
            wrSeen = periphWrite;
            wdSeen = periphWdata;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        cmpCount++;
        if (seen !== exp) begin
            errTotal++;
            $display("Error at %0t: %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask

    task automatic run(input mmd_row_t x);
        int n;
        reqAddr = x.a;
        reqWrite = x.w;
        reqSize = x.s;
        reqWdata = x.d;
        reqValid = 1'b1;
        n = 0;
        @(negedge ref_clk);
        while (reqReady !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
        #10 reqValid = 1'b0;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (respValid !== 1'b1 && n < 20);
        check(32'(n), 32'(x.lat), "answer latency");
        check(32'(respUnmapped), 32'(x.u), "unmapped flag");
        if (!x.w) begin
            check(respRdata, x.r, "read data");
        end
        @(posedge ref_clk);
        #10;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        run('{a, 1'b1, SIZE_WORD, d, 32'h0, 1, 1'b0});
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e, input int lat);
        run('{a, 1'b0, SIZE_WORD, 32'h0, e, lat, 1'b0});
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #2_000_000;
        errTotal++;
        conclude();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst, reqValid, reqWrite, reqSize, reqAddr, reqWdata, resetCauseSet} = '0;
        rst = 1'b1;
        repeat (4) @(posedge ref_clk);
        check(32'(addrZeroSelect), 32'h1, "remap after reset");
        check(32'(reqReady), 32'h1, "ready in reset");
        check(32'(respValid), 32'h0, "no answer in reset");
        #10 rst = 1'b0;
        foreach (rows[i]) begin
            run(rows[i]);
        end
        run('{32'h0009_f800, 1'b0, SIZE_HALF, 32'h0, 32'h0000_c000, 1, 1'b0});
        check(32'(bootSeen), 32'h1, "boot page flag");
        check(32'(pageSeen), 32'hfc, "boot page index");
        run('{32'h0009_f7fe, 1'b0, SIZE_HALF, 32'h0, 32'hc7ff_0000, 1, 1'b0});
        check(32'(bootSeen), 32'h0, "user page flag");
        check(32'(pageSeen), 32'hfb, "user page index");
        run('{32'hffff_0300, 1'b1, SIZE_WORD, 32'hbeef_0123, 32'h0, 2, 1'b0});
        check(32'(fastSeen), 32'h0, "slow bus flag");
        check(32'(wrSeen), 32'h1, "held write strobe");
        check(wdSeen, 32'hbeef_0123, "held write data");
        run('{32'hffff_0d04, 1'b0, SIZE_WORD, 32'h0, 32'ha5c3_0d04, 1, 1'b0});
        check(32'(fastSeen), 32'h1, "fast bus flag");
        check(32'(wrSeen), 32'h0, "read strobe");
        resetCauseSet = 8'h05;
        @(posedge ref_clk);
        #10 resetCauseSet = 8'h00;
        rd(32'hffff_0230, 32'h05, 1);
        wr(32'hffff_0234, 32'h01);
        rd(32'hffff_0230, 32'h04, 1);
        fork
            wr(32'hffff_0234, 32'h04);
            begin
                resetCauseSet = 8'h04;
                @(posedge ref_clk);
                #10 resetCauseSet = 8'h00;
            end
        join
        rd(32'hffff_0230, 32'h04, 1);
        wr(32'hffff_0248, 32'h5a);
        wr(32'hffff_024c, 32'h3c);
        wr(32'hffff_0250, 32'ha5);
        check(32'(resetSetup), 32'h3c, "keyed setup");
        wr(32'hffff_0248, 32'h5a);
        wr(32'hffff_024c, 32'h77);
        wr(32'hffff_0234, 32'h00);
        wr(32'hffff_0250, 32'ha5);
        rd(32'hffff_024c, 32'h3c, 1);
        wr(32'hffff_0220, 32'h0);
        rst = 1'b1;
        @(negedge ref_clk);
        check(32'(addrZeroSelect), 32'h1, "remap after second reset");
        check(32'(resetSetup), 32'h0, "setup after second reset");
        @(posedge ref_clk);
        #10 rst = 1'b0;
        rd(32'h0000_0000, 32'h3c01_3c00, 2);
        conclude();
    end
endmodule
